//--- logic/rhpi_pkg.sv
// Purpose: shared constants for the reader host pin interface
// Assumes: 10 MHz system clock, serial clock sampled as ordinary input
// Notes:   no software-visible registers; configuration arrives on ports
//
// Operation
// - strap low answers read 51, write 50
// - strap high answers read D5, write D4
// - clock output defaults to lowest rate; here the rate port sets it from reset, RATE_RESET is unused
// - two-bit rate field selects output frequency
// - disable bit stops the clock output
// - select low runs two-wire slave
// - select high runs SPI mode 0 slave
// - handshake high while a byte waits
// - handshake low when output buffer empty
// - commands ignored while handshake high
// - low reset input resets the device
// - host serial clock clocks both modes
// - data-in pin is SPI input or open-drain
// - data-out pin drives SPI data only
// - target select frames SPI transfers
// - data-out released after target select rises
package rhpi_pkg;

    // ************************************************************
    // two-wire address bytes
    // ************************************************************
    localparam logic [7:0] ADDR_RD_LOW  = 8'h51;
    localparam logic [7:0] ADDR_WR_LOW  = 8'h50;
    localparam logic [7:0] ADDR_RD_HIGH = 8'hD5;
    localparam logic [7:0] ADDR_WR_HIGH = 8'hD4;

    // ************************************************************
    // divided clock output: 10 MHz cannot reach the documented rates,
    // so each rate is a half-period count rounded down, at least one
    // ************************************************************
    localparam int CLK_HZ        = 10000000;
    localparam int RATE0_KHZ     = 1978;
    localparam int RATE1_KHZ     = 3955;
    localparam int RATE2_KHZ     = 7910;
    localparam int RATE3_KHZ     = 15820;
    localparam int HALF_W        = 4;
    localparam logic [1:0] RATE_RESET = 2'h0;

    function automatic logic [HALF_W-1:0] half_cycles(input int khz);
        int n;
        n = CLK_HZ / (2 * khz * 1000);
        if (n < 1) begin
            n = 1;
        end
        return HALF_W'(n);
    endfunction : half_cycles

    // ************************************************************
    // serial port
    // ************************************************************
    localparam int BIT_CNT_W  = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_RX, ST_ACK_RX, ST_TX,
                  ST_ACK_TX, ST_SKIP} rhpi_tw_state_t;

endpackage : rhpi_pkg

//--- logic/rhpi_clk_div.sv
// Purpose: programmable divided clock output
// Assumes: rate and disable come from the system clock domain
// Notes:   output is a register; stops low when disabled
module rhpi_clk_div (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // control
    input  wire logic [1:0] rate,
    input  wire logic       clock_output_disable,
    // output
    output logic            divided_clock_output
);
    // half-period counts for each rate, decoded by one wire
    logic [rhpi_pkg::HALF_W-1:0] half_len;
    logic [rhpi_pkg::HALF_W-1:0] count;
    logic                        wrap;

    assign half_len = (rate == 2'h0) ? rhpi_pkg::half_cycles(rhpi_pkg::RATE0_KHZ) :
                      (rate == 2'h1) ? rhpi_pkg::half_cycles(rhpi_pkg::RATE1_KHZ) :
                      (rate == 2'h2) ? rhpi_pkg::half_cycles(rhpi_pkg::RATE2_KHZ) :
                                       rhpi_pkg::half_cycles(rhpi_pkg::RATE3_KHZ);
    assign wrap = (count + 4'h1 >= half_len);

    // toggle each half period; disable holds output low and counter idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count                <= '0;
            divided_clock_output <= 1'b0;
        end else if (clock_output_disable) begin
            count                <= '0;
            divided_clock_output <= 1'b0;
        end else if (wrap) begin
            count                <= '0;
            divided_clock_output <= ~divided_clock_output;
        end else begin
            count <= count + 4'h1;
        end
    end

    AST_CLK_STOPS: assert property (@(posedge clk) disable iff (!reset_n)
        clock_output_disable |=> !divided_clock_output)
        else $error("clock output runs while disabled");
endmodule : rhpi_clk_div

//--- logic/rhpi_top.sv
// Purpose: host serial port (two-wire or SPI mode 0) with handshake
// Assumes: serial clock, data, select pins are asynchronous; two-flop synced
// Notes:   one byte of transmit buffer, one byte of receive output
module rhpi_top (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    // static straps
    input  wire logic       INTERFACE_SELECT,
    input  wire logic       ADDR_STRAP,
    // serial pins
    input  wire logic       SERIAL_CLOCK,
    input  wire logic       TARGET_SELECT_N,
    input  wire logic       SERIAL_IN_IO_IN,
    output logic            SERIAL_IN_IO_OUT,
    output logic            SERIAL_IN_IO_OE_N,
    output logic            SERIAL_OUT_PIN,
    output logic            SERIAL_OUT_PIN_OE_N,
    // handshake
    output logic            HANDSHAKE,
    // device core: reply byte in, command byte out
    input  wire logic [7:0] REPLY_DATA,
    input  wire logic       REPLY_VALID,
    output logic            REPLY_READY,
    output logic [7:0]      CMD_DATA,
    output logic            CMD_VALID,
    // clock output control
    input  wire logic [1:0] CLOCK_RATE,
    input  wire logic       CLOCK_OUTPUT_DISABLE,
    output logic            DIVIDED_CLOCK_OUTPUT
);
    // ************************************************************
    // synchronisers and straps
    // ************************************************************
    logic [2:0] sync1;            // first stage, read only by sync2
    logic [2:0] sync2;            // second stage: sck, ss_n, sda
    logic       sck_d;            // previous synced clock
    logic       sda_d;            // previous synced data
    logic       spi_mode;         // latched interface select
    logic       addr_high;        // latched address strap
    logic       strap_taken;      // straps sampled once after release

    // two flops on every serial pin that crosses in; straps are sampled directly
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sck_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {SERIAL_IN_IO_IN, TARGET_SELECT_N, SERIAL_CLOCK};
            sync2 <= sync1;
            sck_d <= sync2[0];
            sda_d <= sync2[2];
        end
    end

    // straps caught on the first edge after release; not a reset value
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_taken <= 1'b0;
            spi_mode    <= 1'b0;
            addr_high   <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            spi_mode    <= INTERFACE_SELECT;
            addr_high   <= ADDR_STRAP;
        end
    end

    // ************************************************************
    // edge and condition decode
    // ************************************************************
    wire sck      = sync2[0];
    wire ss_n     = sync2[1];
    wire sda      = sync2[2];
    wire sck_rise = sck & ~sck_d;
    wire sck_fall = ~sck & sck_d;
    wire tw_start = !spi_mode && sck && sda_d && !sda;
    wire tw_stop  = !spi_mode && sck && !sda_d && sda;
    wire spi_on   = spi_mode && !ss_n && strap_taken;
    wire [7:0] my_wr = addr_high ? rhpi_pkg::ADDR_WR_HIGH : rhpi_pkg::ADDR_WR_LOW;

    // ************************************************************
    // shared byte datapath
    // ************************************************************
    logic [7:0] shift_in;         // received bits, msb first
    logic [7:0] shift_out;        // bits to send, msb first
    logic [3:0] bit_cnt;          // bits of current byte
    logic [7:0] tx_buf;           // one byte waiting for the host
    logic       tx_full;          // byte waiting flag, drives handshake
    logic       load_tx;          // host took buffer byte: SPI at byte end, two-wire at read start
    logic       cmd_take;         // a whole command byte arrived
    rhpi_pkg::rhpi_tw_state_t tw_state;

    wire [7:0] next_shift_in = {shift_in[6:0], spi_mode ? sda : sda};
    wire       byte_done     = (bit_cnt == rhpi_pkg::BITS_PER_BYTE - 4'h1) && sck_rise;
    wire       addr_hit      = (next_shift_in[7:1] == my_wr[7:1]);
    // byte the host reads next, zero when the buffer is empty
    wire [7:0] tx_load       = tx_full ? tx_buf : 8'h00;
    // line changes are looked ahead by one cycle: the synced clock is two
    // cycles late, so a later change would meet the host's next rising clock
    wire       tw_to_tx      = (tw_state == rhpi_pkg::ST_ACK_ADDR) && sck_fall
                               && (bit_cnt == rhpi_pkg::BITS_PER_BYTE) && shift_in[0];
    wire       tw_in_ack     = (tw_state == rhpi_pkg::ST_ACK_ADDR)
                               || (tw_state == rhpi_pkg::ST_ACK_RX);
    wire       tw_ack        = tw_in_ack && ((bit_cnt == rhpi_pkg::BITS_PER_BYTE) != sck_fall);
    wire       tw_hold_last  = (tw_state == rhpi_pkg::ST_ACK_TX)
                               && (bit_cnt == rhpi_pkg::BITS_PER_BYTE) && !sck_fall;
    wire       tw_bit_on     = tw_to_tx || (tw_state == rhpi_pkg::ST_TX) || tw_hold_last;
    wire       tw_next_bit   = tw_to_tx ? tx_load[7]
                             : (sck_fall && tw_state == rhpi_pkg::ST_TX) ? shift_out[6]
                             : shift_out[7];
    wire       tw_zero       = tw_bit_on && !tw_next_bit;
    wire       spi_next_bit  = !sck_fall ? shift_out[7]
                             : (bit_cnt == 4'h0) ? tx_load[7] : shift_out[6];

    // buffer accepts a reply byte when empty; handshake is registered from this flag
    assign REPLY_READY = !tx_full;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_full <= 1'b0;
            tx_buf  <= 8'h00;
        end else if (REPLY_VALID && !tx_full) begin
            tx_full <= 1'b1;
            tx_buf  <= REPLY_DATA;
        end else if (load_tx) begin
            tx_full <= 1'b0;
        end
    end

    // handshake pin registered from the buffer flag or a reply byte being accepted
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            HANDSHAKE <= 1'b0;
        end else begin
            HANDSHAKE <= tx_full || (REPLY_VALID && !tx_full);
        end
    end

    // command out: dropped while a byte is waiting for the host
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CMD_DATA  <= 8'h00;
            CMD_VALID <= 1'b0;
        end else begin
            CMD_VALID <= cmd_take && !tx_full;
            if (cmd_take) begin
                CMD_DATA <= next_shift_in;
            end
        end
    end

    // ************************************************************
    // serial engine: SPI mode 0 sample on rise, shift on fall;
    // two-wire: sample on rise, drive on fall, ack ninth bit
    // ************************************************************
    always_comb begin
        load_tx  = 1'b0;
        cmd_take = 1'b0;
        if (spi_on) begin
            cmd_take = byte_done;
            load_tx  = byte_done && tx_full;
        end else if (!spi_mode) begin
            cmd_take = byte_done && (tw_state == rhpi_pkg::ST_RX);
            load_tx  = tw_to_tx && tx_full;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            shift_in  <= 8'h00;
            shift_out <= 8'h00;
            bit_cnt   <= 4'h0;
            tw_state  <= rhpi_pkg::ST_IDLE;
        end else if (spi_mode) begin
            tw_state <= rhpi_pkg::ST_IDLE;
            if (!spi_on) begin
                bit_cnt   <= 4'h0;
                shift_out <= tx_full ? tx_buf : 8'h00;
            end else if (sck_rise) begin
                shift_in <= next_shift_in;
                bit_cnt  <= byte_done ? 4'h0 : bit_cnt + 4'h1;
            end else if (sck_fall) begin
                shift_out <= (bit_cnt == 4'h0) ? (tx_full ? tx_buf : 8'h00)
                                               : {shift_out[6:0], 1'b0};
            end
        end else if (tw_start) begin
            tw_state <= rhpi_pkg::ST_ADDR;
            bit_cnt  <= 4'h0;
        end else if (tw_stop) begin
            tw_state <= rhpi_pkg::ST_IDLE;
        end else begin
            case (tw_state)
                rhpi_pkg::ST_ADDR: begin
                    // count restarts so the ack phase can tell its two falls apart
                    if (sck_rise) begin
                        shift_in <= next_shift_in;
                        bit_cnt  <= byte_done ? 4'h0 : bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        tw_state <= addr_hit ? rhpi_pkg::ST_ACK_ADDR : rhpi_pkg::ST_SKIP;
                    end
                end
                rhpi_pkg::ST_ACK_ADDR: begin
                    if (sck_fall && bit_cnt == rhpi_pkg::BITS_PER_BYTE) begin
                        bit_cnt <= 4'h0;
                        tw_state <= shift_in[0] ? rhpi_pkg::ST_TX : rhpi_pkg::ST_RX;
                        shift_out <= tx_full ? tx_buf : 8'h00;
                    end else if (sck_fall) begin
                        bit_cnt <= rhpi_pkg::BITS_PER_BYTE;
                    end
                end
                rhpi_pkg::ST_RX: begin
                    if (sck_rise) begin
                        shift_in <= next_shift_in;
                        bit_cnt  <= byte_done ? 4'h0 : bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        tw_state <= rhpi_pkg::ST_ACK_RX;
                    end
                end
                rhpi_pkg::ST_ACK_RX: begin
                    if (sck_fall && bit_cnt == rhpi_pkg::BITS_PER_BYTE) begin
                        bit_cnt  <= 4'h0;
                        tw_state <= rhpi_pkg::ST_RX;
                    end else if (sck_fall) begin
                        bit_cnt <= rhpi_pkg::BITS_PER_BYTE;
                    end
                end
                rhpi_pkg::ST_TX: begin
                    if (sck_fall && bit_cnt != 4'h0) begin
                        shift_out <= {shift_out[6:0], 1'b0};
                    end
                    if (sck_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        tw_state <= rhpi_pkg::ST_ACK_TX;
                    end
                end
                rhpi_pkg::ST_ACK_TX: begin
                    // host nack or ack ends our part; wait for stop
                    // the fall ends our last data bit and frees the line
                    if (sck_fall) begin
                        bit_cnt <= 4'h0;
                    end
                    if (sck_rise) begin
                        tw_state <= rhpi_pkg::ST_SKIP;
                    end
                end
                rhpi_pkg::ST_SKIP: begin
                    bit_cnt <= 4'h0;
                end
                default: begin
                    tw_state <= rhpi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // pin drivers, all registered
    // ************************************************************
    wire next_sda_oe_n  = !(tw_ack || tw_zero) || spi_mode;
    wire next_sdo_oe_n  = !spi_on;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SERIAL_IN_IO_OUT    <= 1'b0;
            SERIAL_IN_IO_OE_N   <= 1'b1;
            SERIAL_OUT_PIN      <= 1'b0;
            SERIAL_OUT_PIN_OE_N <= 1'b1;
        end else begin
            SERIAL_IN_IO_OUT    <= 1'b0;               // open drain: pulls low only
            SERIAL_IN_IO_OE_N   <= next_sda_oe_n;
            SERIAL_OUT_PIN      <= spi_on & spi_next_bit;
            SERIAL_OUT_PIN_OE_N <= next_sdo_oe_n;
        end
    end

    // ************************************************************
    // clock output
    // ************************************************************
    rhpi_clk_div u_clk_div (
        .clk                  (CLK),
        .reset_n              (RESET_N),
        .rate                 (CLOCK_RATE),
        .clock_output_disable (CLOCK_OUTPUT_DISABLE),
        .divided_clock_output (DIVIDED_CLOCK_OUTPUT)
    );

    // ************************************************************
    // checks
    // ************************************************************
    AST_HS_FOLLOWS: assert property (@(posedge CLK) disable iff (!RESET_N)
        tx_full |=> HANDSHAKE) else $error("handshake low with byte waiting");
    AST_HS_EMPTY: assert property (@(posedge CLK) disable iff (!RESET_N)
        (!tx_full && !REPLY_VALID) |=> !HANDSHAKE) else $error("handshake high when empty");
    AST_CMD_BLOCK: assert property (@(posedge CLK) disable iff (!RESET_N)
        (cmd_take && tx_full) |=> !CMD_VALID) else $error("command taken while busy");
    AST_SDO_RELEASE: assert property (@(posedge CLK) disable iff (!RESET_N)
        (spi_mode && ss_n) |=> SERIAL_OUT_PIN_OE_N) else $error("data-out not released");
    AST_SDO_TW: assert property (@(posedge CLK) disable iff (!RESET_N)
        !spi_mode |=> SERIAL_OUT_PIN_OE_N) else $error("data-out driven in two-wire");
    AST_SDA_SPI: assert property (@(posedge CLK) disable iff (!RESET_N)
        spi_mode |=> SERIAL_IN_IO_OE_N) else $error("data-in driven in SPI");
    AST_STRAP_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
        strap_taken |=> $stable(spi_mode) && $stable(addr_high)) else $error("strap changed");
    AST_ADDR_ACK: assert property (@(posedge CLK) disable iff (!RESET_N)
        (tw_state == rhpi_pkg::ST_ADDR && byte_done && addr_hit) |=>
        tw_state == rhpi_pkg::ST_ACK_ADDR) else $error("own address not acked");

    COV_SPI_CMD: cover property (@(posedge CLK) spi_on && CMD_VALID);
    COV_TW_CMD: cover property (@(posedge CLK) !spi_mode && CMD_VALID);
    COV_TW_READ: cover property (@(posedge CLK) tw_state == rhpi_pkg::ST_TX);
    COV_BUSY_DROP: cover property (@(posedge CLK) cmd_take && tx_full);
endmodule : rhpi_top

//--- bench/rhpi_host_model.sv
// Purpose: host master model for the serial port, SPI mode 0 and two-wire
// Assumes: four system clocks per serial half period (800 ns serial clock)
// Notes:   serial clock stands still between frames; data line has a pull-up
module rhpi_host_model (
    // system clock
    input  wire logic clk,
    // device side of the pins
    input  wire logic dev_oe_n,
    input  wire logic dev_miso,
    input  wire logic sel_spi,
    // host pins
    output logic      sck,
    output logic      tsel_n,
    output logic      data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_drv;  // host open-drain drive, 0 pulls the line low
    logic mosi;      // host data in SPI mode

    // wired-and with pull-up in two-wire mode, plain input in SPI mode
    assign data_in = sel_spi ? mosi : (host_drv & dev_oe_n);

    initial begin
        sck = 1'b0;
        tsel_n = 1'b1;
        host_drv = 1'b1;
        mosi = 1'b0;
    end

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // idle levels: SPI clock low, two-wire clock high, select tied low in two-wire
    task idle(input logic spi);
        sck <= ~spi;
        host_drv <= 1'b1;
        tsel_n <= spi;
    endtask : idle

    // one framed SPI byte, msb first, sample before each rising clock
    task spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
        tsel_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            cyc(4);
            rx[i] = dev_miso;
            sck <= 1'b1;
            cyc(4);
            sck <= 1'b0;
        end
        cyc(4);
        tsel_n <= 1'b1;
        mosi <= ~mosi;  // released line must not keep its last value
        cyc(4);
    endtask : spi_xfer

    // data changes only well inside the low phase, so no false start or stop
    task tw_bit(input logic b, output logic lvl);
        sck <= 1'b0;
        cyc(2);
        host_drv <= b;
        cyc(2);
        sck <= 1'b1;
        cyc(3);
        lvl = data_in;
        cyc(1);
    endtask : tw_bit

    task tw_byte(input logic [7:0] b, output logic ack);
        logic l;
        for (int i = 7; i >= 0; i--) begin
            tw_bit(b[i], l);
        end
        tw_bit(1'b1, l);
        ack = ~l;
    endtask : tw_byte

    task tw_start;
        sck <= 1'b1;
        host_drv <= 1'b1;
        cyc(4);
        host_drv <= 1'b0;
        cyc(4);
    endtask : tw_start

    task tw_stop;
        logic l;
        tw_bit(1'b0, l);
        host_drv <= 1'b1;
        cyc(4);
    endtask : tw_stop
endmodule : rhpi_host_model

//--- bench/tb_top.sv
// Purpose: self-checking bench for the reader host pin interface
// Assumes: 10 MHz system clock, host model as serial master
// Notes:   expected values come from the documented pin behaviour
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, reset_n, if_sel, strap, sck, tsel_n, din, reply_valid, clk_dis;
    logic       io_out, io_oe_n, miso, miso_oe_n, handshake, reply_ready, cmd_valid;
    logic       div_clk;
    logic [7:0] reply_data, cmd_data, last_cmd, rx;
    logic [1:0] rate;
    int         fail_count, tests_run, cycles, cmd_count;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    rhpi_top DUT (.CLK(clk), .RESET_N(reset_n), .INTERFACE_SELECT(if_sel),
        .ADDR_STRAP(strap), .SERIAL_CLOCK(sck), .TARGET_SELECT_N(tsel_n),
        .SERIAL_IN_IO_IN(din), .SERIAL_IN_IO_OUT(io_out), .SERIAL_IN_IO_OE_N(io_oe_n),
        .SERIAL_OUT_PIN(miso), .SERIAL_OUT_PIN_OE_N(miso_oe_n), .HANDSHAKE(handshake),
        .REPLY_DATA(reply_data), .REPLY_VALID(reply_valid), .REPLY_READY(reply_ready),
        .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid), .CLOCK_RATE(rate),
        .CLOCK_OUTPUT_DISABLE(clk_dis), .DIVIDED_CLOCK_OUTPUT(div_clk));

    rhpi_host_model host (.clk(clk), .dev_oe_n(io_oe_n), .dev_miso(miso),
        .sel_spi(if_sel), .sck(sck), .tsel_n(tsel_n), .data_in(din));

    // command monitor and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cmd_valid === 1'b1) begin
            cmd_count++;
            last_cmd = cmd_data;
        end
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task print_verdict;
        $display("tests run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // straps are set before release; reset held five cycles
    task reset_dut(input logic sel, input logic st);
        if_sel <= sel;
        strap <= st;
        host.idle(sel);
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : reset_dut

    // core hands one byte, held until the ready edge
    task load_reply(input logic [7:0] b);
        reply_data <= b;
        reply_valid <= 1'b1;
        do @(posedge clk); while (reply_ready !== 1'b1);
        reply_valid <= 1'b0;
        @(negedge clk);
        check("handshake full", 8'h01, {7'h0, handshake});
        check("ready full", 8'h00, {7'h0, reply_ready});
    endtask : load_reply

    task test_reset;
        repeat (2) @(negedge clk);
        check("handshake in reset", 8'h00, {7'h0, handshake});
        check("io enable in reset", 8'h01, {7'h0, io_oe_n});
        check("out enable in reset", 8'h01, {7'h0, miso_oe_n});
        check("ready in reset", 8'h01, {7'h0, reply_ready});
        $display("test reset done");
    endtask : test_reset

    // two back-to-back commands with an empty buffer
    task test_spi_cmd;
        int n;
        n = cmd_count;
        host.spi_xfer(8'hA5, rx);
        host.spi_xfer(8'h5A, rx);
        repeat (6) @(posedge clk);
        check("spi cmd count", 8'h02, 8'(cmd_count - n));
        check("spi cmd data", 8'h5A, last_cmd);
        check("spi empty readback", 8'h00, rx);
        check("out released", 8'h01, {7'h0, miso_oe_n});
        $display("test spi command done");
    endtask : test_spi_cmd

    // a command sent while a byte waits is dropped; the byte comes out
    task test_spi_reply;
        int n;
        load_reply(8'h3C);
        n = cmd_count;
        host.spi_xfer(8'h77, rx);
        repeat (6) @(posedge clk);
        check("spi reply data", 8'h3C, rx);
        check("cmd ignored", 8'h00, 8'(cmd_count - n));
        check("handshake empty", 8'h00, {7'h0, handshake});
        $display("test spi reply done");
    endtask : test_spi_reply

    // high phase of each rate, counted in system clocks, then disable
    task test_clock;
        int khz [4];
        int e, k, n;
        khz = '{rhpi_pkg::RATE0_KHZ, rhpi_pkg::RATE1_KHZ,
                rhpi_pkg::RATE2_KHZ, rhpi_pkg::RATE3_KHZ};
        for (int r = 0; r < 4; r++) begin
            rate <= 2'(r);
            repeat (8) @(negedge clk);
            k = 0;
            while (div_clk !== 1'b0 && k < 20) begin @(negedge clk); k++; end
            while (div_clk !== 1'b1 && k < 40) begin @(negedge clk); k++; end
            n = 0;
            while (div_clk === 1'b1 && n < 20) begin @(negedge clk); n++; end
            e = rhpi_pkg::CLK_HZ / (2 * khz[r] * 1000);
            if (e < 1) e = 1;
            check("clock half period", 8'(e), 8'(n));
        end
        clk_dis <= 1'b1;
        repeat (3) @(negedge clk);
        n = 0;
        repeat (20) begin @(negedge clk); if (div_clk !== 1'b0) n++; end
        check("clock stopped", 8'h00, 8'(n));
        clk_dis <= 1'b0;
        rate <= 2'h0;
        $display("test clock done");
    endtask : test_clock

    // write, foreign address, then read; strap moved after release
    task test_two_wire(input logic st, input logic [7:0] wr, input logic [7:0] bad);
        logic ack, l;
        int n;
        reset_dut(1'b0, st);
        strap <= ~st;
        host.tw_start();
        host.tw_byte(wr, ack);
        check("addr ack", 8'h01, {7'h0, ack});
        host.tw_byte(8'hC3, ack);
        check("data ack", 8'h01, {7'h0, ack});
        host.tw_stop();
        check("tw cmd data", 8'hC3, last_cmd);
        check("out unused", 8'h01, {7'h0, miso_oe_n});
        n = cmd_count;
        host.tw_start();
        host.tw_byte(bad, ack);
        check("foreign addr", 8'h00, {7'h0, ack});
        host.tw_byte(8'h11, ack);
        host.tw_stop();
        check("foreign cmd", 8'h00, 8'(cmd_count - n));
        load_reply(8'h96);
        host.tw_start();
        host.tw_byte(wr | 8'h01, ack);
        check("read addr ack", 8'h01, {7'h0, ack});
        for (int i = 7; i >= 0; i--) begin host.tw_bit(1'b1, l); rx[i] = l; end
        host.tw_bit(1'b1, l);
        host.tw_stop();
        check("tw read data", 8'h96, rx);
        check("tw handshake", 8'h00, {7'h0, handshake});
        $display("test two-wire done");
    endtask : test_two_wire

    initial begin
        {reset_n, if_sel, strap, reply_valid, clk_dis} = 5'h00;
        reply_data = 8'h00;
        rate = 2'h0;
        test_reset();
        reset_dut(1'b1, 1'b0);
        test_spi_cmd();
        test_spi_reply();
        test_clock();
        test_two_wire(1'b0, 8'h50, 8'hD4);
        test_two_wire(1'b1, 8'hD4, 8'h50);
        print_verdict();
    end
endmodule : tb_top
